// ===== shared/pwl_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types of the password lock
// ----------------------------------------------------------------------------
package pwl_pkg;

   // Setting values, all decimal quantities held as binary words
   localparam logic [15:0] PWL_NO_LOCK = 16'h270f;      // 9999, no password lock
   localparam logic [15:0] PWL_LOCK_RESET = 16'h270f;   // Lock level after reset
   localparam logic [15:0] PWL_PASS_RESET = 16'h270f;   // Password after reset
   localparam logic [15:0] PWL_PASS_MIN = 16'h03e8;     // 1000
   localparam logic [15:0] PWL_PASS_MAX = 16'h270e;     // 9998
   localparam logic [15:0] PWL_EXT_BASE = 16'h0064;     // 100, counted levels start above
   localparam logic [15:0] PWL_LVL_MIN = 16'h0001;      // Lowest units digit
   localparam logic [15:0] PWL_LVL_MAX = 16'h0006;      // Highest units digit
   localparam logic [15:0] PWL_RD_ZERO = 16'h0000;      // Read value of an ordinary item
   localparam int PWL_ERR_LIMIT = 5;                     // Unlock errors before hard lock
   localparam int PWL_ERR_W = 3;                         // Width of the error count

   // Rights bit positions returned by the level decoder
   localparam int PWL_RT_LOC_RD = 0;
   localparam int PWL_RT_LOC_WR = 1;
   localparam int PWL_RT_NET_RD = 2;
   localparam int PWL_RT_NET_WR = 3;
   localparam int PWL_RT_W = 4;

   // Requested operation
   typedef enum logic [2:0] {
      PWL_OP_READ,
      PWL_OP_WRITE,
      PWL_OP_CLEAR,
      PWL_OP_ALL_CLEAR,
      PWL_OP_COPY
   } pwl_op_type;

   // Item that a read or write addresses
   typedef enum logic [1:0] {
      PWL_TGT_ORDINARY,
      PWL_TGT_LOCK_LEVEL,
      PWL_TGT_PASSWORD,
      PWL_TGT_INTERNAL
   } pwl_target_type;

   // Source class of a request
   typedef enum logic [1:0] {
      PWL_SRC_OTHER,
      PWL_SRC_LOCAL,
      PWL_SRC_NET
   } pwl_src_type;

   // Lock state
   typedef enum logic {
      PWL_ST_OPEN,
      PWL_ST_LOCKED
   } pwl_state_type;

endpackage

// ===== logic/pwl_rights.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Level decoder: access rights and level classes
// ----------------------------------------------------------------------------
module pwl_rights (
   // Lock level setting
   input wire logic [15:0] i_level,
   // Decoded rights and classes
   output logic [pwl_pkg::PWL_RT_W-1:0] o_rights,
   output logic o_valid,
   output logic o_counted,
   output logic o_no_lock
);
   import pwl_pkg::*;

   // Units digit of a level, zero for any other value
   function automatic logic [15:0] units_of(input logic [15:0] lvl);
      logic [15:0] u;
      u = (lvl > PWL_EXT_BASE) ? 16'(lvl - PWL_EXT_BASE) : lvl;
      units_of = (u >= PWL_LVL_MIN && u <= PWL_LVL_MAX) ? u : 16'h0000;
   endfunction

   logic [15:0] units;
   logic in_low;
   logic in_ext;

   // Level classes
   assign units = units_of(i_level);
   assign in_low = (i_level >= PWL_LVL_MIN) && (i_level <= PWL_LVL_MAX);
   assign in_ext = (i_level > PWL_EXT_BASE) && (i_level <= 16'(PWL_EXT_BASE + PWL_LVL_MAX));
   assign o_no_lock = (i_level == PWL_NO_LOCK);
   assign o_valid = in_low || in_ext || o_no_lock;
   assign o_counted = in_ext;

   // Rights table, order net_wr net_rd loc_wr loc_rd
   always_comb begin
      case (units)
         16'h0001: o_rights = 4'b0101;
         16'h0002: o_rights = 4'b1101;
         16'h0003: o_rights = 4'b0111;
         16'h0004: o_rights = 4'b0000;
         16'h0005: o_rights = 4'b1100;
         16'h0006: o_rights = 4'b0011;
         default: o_rights = 4'b1111;
      endcase
   end

endmodule // pwl_rights

// ===== logic/pwl_lock.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Parameter password lock
// ----------------------------------------------------------------------------
// How it works
// - Lock level takes 1-6, 101-106, or 9999
// - Password accepts 1000 to 9998, registers it
// - Units digit selects local and network rights
// - Display hiding and write selection still refuse
// - Network class: RS-485 in network mode
// - Counted levels track errors, others read zero
// - Five errors: correct password no longer unlocks
// - Password write refused while level is 9999
// - Registered password enforces level until unlock
// - Registered password reads back error count only
// - Correct password unlocks, wrong raises error
// - All clear releases lock, resets all settings
// - All clear refused while output voltage active
// - Locked: no level write, clear, copy
// - Internal updates always written despite lock
// - Password writable regardless of display hiding
// - Local write restriction disables easy mode switching
// - Levels 4,5,104,105 disable panel jog run
// - Restricted access refused with password error flag
module pwl_lock #(
   parameter int ERR_LIMIT = pwl_pkg::PWL_ERR_LIMIT
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Parameter access request
   input wire logic i_req_valid,
   input wire pwl_pkg::pwl_op_type i_req_op,
   input wire pwl_pkg::pwl_target_type i_req_target,
   input wire logic [15:0] i_req_wdata,
   // Source of the request
   input wire logic i_src_rs485,
   input wire logic i_net_mode,
   input wire logic i_src_cmd_unit,
   // Gating from other functions
   input wire logic i_display_hidden,
   input wire logic i_write_forbidden,
   input wire logic i_output_active,
   // Answer
   output logic o_ack,
   output logic o_grant,
   output logic o_pw_error,
   output logic o_unlock_error,
   output logic [15:0] o_rdata,
   output logic o_all_clear_done,
   // Status
   output logic [15:0] o_lock_level,
   output logic o_locked,
   output logic o_hard_locked,
   output logic [pwl_pkg::PWL_ERR_W-1:0] o_err_count,
   output logic o_easy_switch_en,
   output logic o_panel_jog_en
);
   import pwl_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   // The saturated count must fit the three-bit error counter
   if (ERR_LIMIT < 1 || ERR_LIMIT > 7) begin : g_bad_limit
      $error("pwl_lock: ERR_LIMIT must lie in 1 to 7");
   end

   localparam logic [PWL_ERR_W-1:0] ERR_SAT = PWL_ERR_W'(ERR_LIMIT);
   localparam logic [PWL_ERR_W-1:0] ERR_ZERO = 3'h0;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pwl_state_type state_q, state_d;
   logic [15:0] level_q, level_d;
   logic [15:0] pass_q, pass_d;
   logic [PWL_ERR_W-1:0] err_q, err_d;
   logic ack_q, grant_q, pw_err_q, unl_err_q, done_q;
   logic grant_d, pw_err_d, unl_err_d, done_d;
   logic [15:0] rdata_q, rdata_d;
   logic easy_q, jog_q;
   logic locked_q, locked_d;
   logic hard_q, hard_d;
   logic [PWL_ERR_W-1:0] cnt_q, cnt_d;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   logic [PWL_RT_W-1:0] rights;
   logic lvl_valid, lvl_counted, lvl_none;
   logic new_valid;
   logic nxt_counted;
   pwl_src_type src;
   logic locked;
   logic hard;
   logic rd_ok, wr_ok;
   logic pass_in_range;
   logic pass_match;
   logic [15:0] pass_read;
   logic is_rd, is_wr;
   logic [PWL_ERR_W-1:0] err_inc;

   pwl_rights u_rights (
      .i_level(level_q),
      .o_rights(rights),
      .o_valid(lvl_valid),
      .o_counted(lvl_counted),
      .o_no_lock(lvl_none)
   );

   // Validity of a proposed lock level
   pwl_rights u_new_rights (
      .i_level(i_req_wdata),
      .o_rights(),
      .o_valid(new_valid),
      .o_counted(),
      .o_no_lock()
   );

   // Class of the level that the next edge will hold
   // Only the counted class is needed, for the status flops
   pwl_rights u_next_rights (
      .i_level(level_d),
      .o_rights(),
      .o_valid(),
      .o_counted(nxt_counted),
      .o_no_lock()
   );

   // Source class of the request
   assign src = (i_src_rs485 && i_net_mode) ? PWL_SRC_NET :
                (i_src_cmd_unit ? PWL_SRC_LOCAL : PWL_SRC_OTHER);

   // Lock classes
   // Hard lock only at counted levels; lower levels never saturate
   assign locked = (state_q == PWL_ST_LOCKED);
   assign hard = locked && lvl_counted && (err_q >= ERR_SAT);

   // Right of one source class for a read or a write
   function automatic logic src_right(input pwl_src_type s, input logic [PWL_RT_W-1:0] rt, input logic wr);
      logic loc_ok;
      logic net_ok;
      loc_ok = wr ? rt[PWL_RT_LOC_WR] : rt[PWL_RT_LOC_RD];
      net_ok = wr ? rt[PWL_RT_NET_WR] : rt[PWL_RT_NET_RD];
      // Source other is never restricted by the level
      src_right = (s == PWL_SRC_OTHER) || ((s == PWL_SRC_LOCAL) ? loc_ok : net_ok);
   endfunction

   // Password-level rights, only while a password is registered
   assign rd_ok = !locked || src_right(src, rights, 1'b0);
   assign wr_ok = !locked || src_right(src, rights, 1'b1);

   // Password value checks
   assign pass_in_range = (i_req_wdata >= PWL_PASS_MIN) && (i_req_wdata <= PWL_PASS_MAX);
   assign pass_match = (i_req_wdata == pass_q);
   assign err_inc = (err_q >= ERR_SAT) ? ERR_SAT : PWL_ERR_W'(err_q + 3'h1);

   // Password read value: error count when registered, never the password
   assign pass_read = !locked ? PWL_NO_LOCK :
                      (lvl_counted ? 16'(err_q) : 16'h0000);

   assign is_rd = i_req_valid && (i_req_op == PWL_OP_READ);
   assign is_wr = i_req_valid && (i_req_op == PWL_OP_WRITE);

   // ----------------------------------------------------------------------
   // Request handling
   // ----------------------------------------------------------------------
   // Next state and answer of one request
   always_comb begin
      state_d = state_q;
      level_d = level_q;
      pass_d = pass_q;
      err_d = err_q;
      grant_d = 1'b0;
      pw_err_d = 1'b0;
      unl_err_d = 1'b0;
      done_d = 1'b0;
      rdata_d = 16'h0000;
      if (is_rd) begin
         case (i_req_target)
            // Lock settings stay readable while registered
            PWL_TGT_LOCK_LEVEL: begin
               grant_d = locked || !i_display_hidden;
               rdata_d = grant_d ? level_q : 16'h0000;
            end
            PWL_TGT_PASSWORD: begin
               grant_d = locked || !i_display_hidden;
               rdata_d = grant_d ? pass_read : 16'h0000;
            end
            default: begin
               grant_d = rd_ok && !i_display_hidden;
               pw_err_d = !rd_ok;
               rdata_d = PWL_RD_ZERO;
            end
         endcase
      end else if (is_wr) begin
         case (i_req_target)
            PWL_TGT_INTERNAL: begin
               grant_d = 1'b1;
            end
            PWL_TGT_LOCK_LEVEL: begin
               // Level frozen while a password is registered
               grant_d = !locked && !i_display_hidden && new_valid;
               pw_err_d = locked;
               if (grant_d) begin
                  level_d = i_req_wdata;
               end
            end
            PWL_TGT_PASSWORD: begin
               if (lvl_none) begin
                  grant_d = 1'b0;
               end else if (!locked) begin
                  // Display hiding has no say here
                  grant_d = pass_in_range;
                  if (pass_in_range) begin
                     pass_d = i_req_wdata;
                     state_d = PWL_ST_LOCKED;
                     err_d = ERR_ZERO;
                  end
               end else if (pass_match && !hard) begin
                  grant_d = 1'b1;
                  state_d = PWL_ST_OPEN;
                  pass_d = PWL_PASS_RESET;
                  err_d = ERR_ZERO;
               end else begin
                  // Wrong value, or any value once hard locked
                  unl_err_d = 1'b1;
                  err_d = lvl_counted ? err_inc : ERR_ZERO;
               end
            end
            default: begin
               grant_d = wr_ok && !i_write_forbidden;
               pw_err_d = !wr_ok;
            end
         endcase
      end else if (i_req_valid) begin
         case (i_req_op)
            PWL_OP_CLEAR, PWL_OP_COPY: begin
               grant_d = !locked;
               pw_err_d = locked;
            end
            PWL_OP_ALL_CLEAR: begin
               grant_d = !i_output_active;
               if (!i_output_active) begin
                  // Release in every state and restore initial settings
                  state_d = PWL_ST_OPEN;
                  level_d = PWL_LOCK_RESET;
                  pass_d = PWL_PASS_RESET;
                  err_d = ERR_ZERO;
                  done_d = 1'b1;
               end
            end
            default: begin
               grant_d = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // Lock state and settings
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_q <= PWL_ST_OPEN;
         level_q <= PWL_LOCK_RESET;
         pass_q <= PWL_PASS_RESET;
         err_q <= ERR_ZERO;
      end else begin
         state_q <= state_d;
         level_q <= level_d;
         pass_q <= pass_d;
         err_q <= err_d;
      end
   end

   // One-cycle answer
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
         grant_q <= 1'b0;
         pw_err_q <= 1'b0;
         unl_err_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         ack_q <= i_req_valid;
         grant_q <= grant_d;
         pw_err_q <= pw_err_d;
         unl_err_q <= unl_err_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end

   // Panel feature enables follow the lock one cycle later
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         easy_q <= 1'b1;
         jog_q <= 1'b1;
      end else begin
         easy_q <= !locked || rights[PWL_RT_LOC_WR];
         jog_q <= !locked || rights[PWL_RT_LOC_RD] || !lvl_valid;
      end
   end

   // ----------------------------------------------------------------------
   // Status registers
   // ----------------------------------------------------------------------
   // Next status from the next state, so the flops move with the lock
   assign locked_d = (state_d == PWL_ST_LOCKED);
   assign hard_d = locked_d && nxt_counted && (err_d >= ERR_SAT);
   assign cnt_d = nxt_counted ? err_d : ERR_ZERO;

   // Lock, hard lock and error count held in flops for the outputs
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         locked_q <= 1'b0;
         hard_q <= 1'b0;
         cnt_q <= ERR_ZERO;
      end else begin
         locked_q <= locked_d;
         hard_q <= hard_d;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_ack = ack_q;
   assign o_grant = grant_q;
   assign o_pw_error = pw_err_q;
   assign o_unlock_error = unl_err_q;
   assign o_rdata = rdata_q;
   assign o_all_clear_done = done_q;
   assign o_lock_level = level_q;
   assign o_locked = locked_q;
   assign o_hard_locked = hard_q;
   assign o_err_count = cnt_q;
   assign o_easy_switch_en = easy_q;
   assign o_panel_jog_en = jog_q;

endmodule // pwl_lock

// ===== testbench/pwl_lock_chk.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Port checker of the password lock
// ----------------------------------------------------------------------------
module pwl_lock_chk import pwl_pkg::*; #(
   parameter int ERR_LIMIT = 5
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Request
   input wire logic i_req_valid,
   input wire pwl_pkg::pwl_op_type i_req_op,
   input wire pwl_pkg::pwl_target_type i_req_target,
   input wire logic i_output_active,
   // Answer and status
   input wire logic o_ack,
   input wire logic o_grant,
   input wire logic o_pw_error,
   input wire logic o_unlock_error,
   input wire logic [15:0] o_rdata,
   input wire logic o_all_clear_done,
   input wire logic [15:0] o_lock_level,
   input wire logic o_locked,
   input wire logic o_hard_locked,
   input wire logic [2:0] o_err_count
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Request decodes
   wire wr_pw = i_req_valid && i_req_op == PWL_OP_WRITE && i_req_target == PWL_TGT_PASSWORD;
   wire rd_pw = i_req_valid && i_req_op == PWL_OP_READ && i_req_target == PWL_TGT_PASSWORD;
   wire wr_lv = i_req_valid && i_req_op == PWL_OP_WRITE && i_req_target == PWL_TGT_LOCK_LEVEL;
   wire all_clr = i_req_valid && i_req_op == PWL_OP_ALL_CLEAR;
   chk_ack_follows: assert property (i_req_valid |=> o_ack) else $error("no answer");
   chk_no_stray_ack: assert property (!i_req_valid |=> !o_ack && !o_grant) else $error("stray answer");
   chk_pw_err_refuses: assert property (o_pw_error |-> o_ack && !o_grant) else $error("pw error granted");
   chk_count_bounded: assert property (o_err_count <= ERR_LIMIT) else $error("count above limit");
   chk_hard_lock_def: assert property (o_hard_locked |-> o_locked && o_err_count == ERR_LIMIT)
      else $error("hard lock wrong");
   chk_open_count_zero: assert property (!o_locked |-> o_err_count == 3'h0) else $error("open count");
   chk_pw_no_lock: assert property (wr_pw && o_lock_level == PWL_NO_LOCK |=> !o_grant)
      else $error("password taken at no lock");
   chk_clear_running: assert property (all_clr && i_output_active |=> !o_grant && !o_all_clear_done)
      else $error("all clear while running");
   chk_clear_release: assert property (all_clr && !i_output_active |=> o_all_clear_done && !o_locked
      && o_lock_level == PWL_LOCK_RESET && o_err_count == 3'h0) else $error("all clear result");
   chk_pw_read_count: assert property (rd_pw && o_locked |=> o_grant
      && o_rdata == 16'($past(o_err_count))) else $error("password read value");
   chk_level_frozen: assert property (wr_lv && o_locked |=> o_pw_error && $stable(o_lock_level))
      else $error("level written while locked");
   chk_hard_no_unlock: assert property (wr_pw && o_hard_locked |=> o_unlock_error && o_hard_locked)
      else $error("hard lock released");
endmodule // pwl_lock_chk

bind pwl_lock pwl_lock_chk #(.ERR_LIMIT(ERR_LIMIT)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_req_valid(i_req_valid), .i_req_op(i_req_op), .i_req_target(i_req_target),
   .i_output_active(i_output_active), .o_ack(o_ack), .o_grant(o_grant), .o_pw_error(o_pw_error),
   .o_unlock_error(o_unlock_error), .o_rdata(o_rdata), .o_all_clear_done(o_all_clear_done),
   .o_lock_level(o_lock_level), .o_locked(o_locked), .o_hard_locked(o_hard_locked), .o_err_count(o_err_count));

// ===== testbench/pwl_host.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Request source: panel, parameter unit or serial host
// ----------------------------------------------------------------------------
module pwl_host (
   // Clock
   input wire logic i_clk,
   // Request toward the lock
   output logic o_valid = 1'b0,
   output pwl_pkg::pwl_op_type o_op = pwl_pkg::PWL_OP_READ,
   output pwl_pkg::pwl_target_type o_target = pwl_pkg::PWL_TGT_ORDINARY,
   output logic [15:0] o_wdata = 16'h0000,
   // Source class {serial, network mode, command unit}
   output logic [2:0] o_src = 3'h0
);
   import pwl_pkg::*;
   // One strobed request; data is scrambled once released
   task automatic access(input pwl_op_type op, input pwl_target_type tgt, input logic [15:0] wd,
                         input logic [2:0] src);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_op <= op;
      o_target <= tgt;
      o_wdata <= wd;
      o_src <= src;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_wdata <= ~wd;
   endtask
endmodule // pwl_host

// ===== testbench/tb_pwl_lock.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Bench of the password lock
// ----------------------------------------------------------------------------
module tb_pwl_lock;
   import pwl_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic hid = 1'b0, fbd = 1'b0, run = 1'b0, v, ack, gr, pe, ue, acd, lk, hl, ee, je;
   pwl_op_type op;
   pwl_target_type tg;
   logic [15:0] wd, rdata, lvl, lv;
   logic [2:0] src, cnt, s;
   logic [3:0] r;
   logic rd, wr, nt;
   int n_errors = 0, comparisons = 0, cyc = 0;
   // Rights per units digit: local rd, local wr, net rd, net wr
   logic [3:0] rt [6] = '{4'b1010, 4'b1011, 4'b1110, 4'b0000, 4'b0011, 4'b1100};
   logic [2:0] srcs [4] = '{3'b001, 3'b110, 3'b101, 3'b000};
   pwl_host u_host (.i_clk(i_clk), .o_valid(v), .o_op(op), .o_target(tg), .o_wdata(wd), .o_src(src));
   pwl_lock #(.ERR_LIMIT(5)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(v), .i_req_op(op),
      .i_req_target(tg), .i_req_wdata(wd), .i_src_rs485(src[2]), .i_net_mode(src[1]), .i_src_cmd_unit(src[0]),
      .i_display_hidden(hid), .i_write_forbidden(fbd), .i_output_active(run), .o_ack(ack), .o_grant(gr),
      .o_pw_error(pe), .o_unlock_error(ue), .o_rdata(rdata), .o_all_clear_done(acd), .o_lock_level(lvl),
      .o_locked(lk), .o_hard_locked(hl), .o_err_count(cnt), .o_easy_switch_en(ee), .o_panel_jog_en(je));
   always #5 i_clk = ~i_clk;
   // Hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic conclude();
      if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic ck(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   // One request and its answer; read data compared on reads only
   task automatic ex(input pwl_op_type o, input pwl_target_type t, input logic [15:0] d, input logic [2:0] c,
                     input logic g, input logic e, input logic [15:0] q);
      u_host.access(o, t, d, c);
      #1;
      ck(ack === 1'b1 && gr === g && pe === e && (o != PWL_OP_READ || rdata === q), "answer");
   endtask
   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      ck(lvl === PWL_LOCK_RESET && lk === 1'b0 && ee === 1'b1 && je === 1'b1, "reset state");
      ex(PWL_OP_READ, PWL_TGT_PASSWORD, 16'h0000, 3'b001, 1'b1, 1'b0, PWL_PASS_RESET);
      ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h04d2, 3'b001, 1'b0, 1'b0, 16'h0000);
      ex(PWL_OP_WRITE, PWL_TGT_LOCK_LEVEL, 16'h0007, 3'b001, 1'b0, 1'b0, 16'h0000);
      ex(PWL_OP_WRITE, PWL_TGT_LOCK_LEVEL, 16'h006b, 3'b001, 1'b0, 1'b0, 16'h0000);
      @(posedge i_clk);
      fbd <= 1'b1;
      hid <= 1'b1;
      ex(PWL_OP_WRITE, PWL_TGT_ORDINARY, 16'h0005, 3'b001, 1'b0, 1'b0, 16'h0000);
      ex(PWL_OP_READ, PWL_TGT_ORDINARY, 16'h0000, 3'b110, 1'b0, 1'b0, 16'h0000);
      @(posedge i_clk);
      fbd <= 1'b0;
      for (int k = 0; k < 12; k++) begin
         @(posedge i_clk);
         hid <= 1'b0;
         lv = (k < 6) ? 16'(k + 1) : 16'(k + 95);
         r = rt[k % 6];
         ex(PWL_OP_WRITE, PWL_TGT_LOCK_LEVEL, lv, 3'b001, 1'b1, 1'b0, 16'h0000);
         ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h03e7, 3'b001, 1'b0, 1'b0, 16'h0000);
         ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h04d2, 3'b001, 1'b1, 1'b0, 16'h0000);
         ck(lk === 1'b1 && lvl === lv, "locked");
         // Panel enables follow the lock one cycle later
         @(posedge i_clk);
         #1;
         ck(ee === r[2], "easy switch");
         ck(je === !(k % 6 == 3 || k % 6 == 4), "jog");
         for (int j = 0; j < 4; j++) begin
            s = srcs[j];
            nt = (s == 3'b110);
            rd = (s == 3'b000) || (nt ? r[1] : r[3]);
            wr = (s == 3'b000) || (nt ? r[0] : r[2]);
            ex(PWL_OP_READ, PWL_TGT_ORDINARY, 16'h0000, s, rd, !rd, 16'h0000);
            ex(PWL_OP_WRITE, PWL_TGT_ORDINARY, 16'h0005, s, wr, !wr, 16'h0000);
         end
         ex(PWL_OP_CLEAR, PWL_TGT_ORDINARY, 16'h0000, 3'b001, 1'b0, 1'b1, 16'h0000);
         ex(PWL_OP_COPY, PWL_TGT_ORDINARY, 16'h0000, 3'b001, 1'b0, 1'b1, 16'h0000);
         ex(PWL_OP_WRITE, PWL_TGT_LOCK_LEVEL, 16'h0003, 3'b001, 1'b0, 1'b1, 16'h0000);
         ex(PWL_OP_READ, PWL_TGT_LOCK_LEVEL, 16'h0000, 3'b001, 1'b1, 1'b0, lv);
         ex(PWL_OP_WRITE, PWL_TGT_INTERNAL, 16'h0009, 3'b001, 1'b1, 1'b0, 16'h0000);
         @(posedge i_clk);
         hid <= 1'b1;
         ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h0457, 3'b001, 1'b0, 1'b0, 16'h0000);
         ck(ue === 1'b1 && lk === 1'b1 && cnt === ((k < 6) ? 3'h0 : 3'h1), "wrong password");
         ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h04d2, 3'b001, 1'b1, 1'b0, 16'h0000);
         ck(lk === 1'b0 && cnt === 3'h0, "unlocked");
      end
      @(posedge i_clk);
      hid <= 1'b0;
      ex(PWL_OP_WRITE, PWL_TGT_LOCK_LEVEL, 16'h0065, 3'b001, 1'b1, 1'b0, 16'h0000);
      ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h270e, 3'b001, 1'b1, 1'b0, 16'h0000);
      for (int i = 1; i <= 5; i++) begin
         ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h03e8, 3'b110, 1'b0, 1'b0, 16'h0000);
         ck(cnt === 3'(i) && hl === (i == 5), "error count");
      end
      ex(PWL_OP_WRITE, PWL_TGT_PASSWORD, 16'h270e, 3'b001, 1'b0, 1'b0, 16'h0000);
      ck(ue === 1'b1 && lk === 1'b1 && cnt === 3'h5, "hard lock");
      ex(PWL_OP_READ, PWL_TGT_PASSWORD, 16'h0000, 3'b001, 1'b1, 1'b0, 16'h0005);
      @(posedge i_clk);
      run <= 1'b1;
      ex(PWL_OP_ALL_CLEAR, PWL_TGT_ORDINARY, 16'h0000, 3'b001, 1'b0, 1'b0, 16'h0000);
      @(posedge i_clk);
      run <= 1'b0;
      ex(PWL_OP_ALL_CLEAR, PWL_TGT_ORDINARY, 16'h0000, 3'b001, 1'b1, 1'b0, 16'h0000);
      ck(acd === 1'b1 && lvl === PWL_LOCK_RESET && lk === 1'b0 && cnt === 3'h0, "all clear");
      conclude();
   end
endmodule // tb_pwl_lock
